// ==== src/dcs_regs.sv ====
/*
  Debug capture and status register bank.
  Assumes the core supplies a one-cycle debug entry pulse with its captured
  state, and ring oscillators arrive as free-running asynchronous clocks whose
  counts are presented here already as levels (sampled through two flops).
*/
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
module dcs_regs
  import dcs_pkg::*;
#(
  parameter logic [31:0] MEM_BYTES = 32'h0008_0000
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             rst,
  // Register port.
  input  wire dcs_req_t         req,
  output logic [31:0]           rdata_q,
  // Debug entry from the core.
  input  wire dcs_entry_t       entry,
  // Raw oscillator counts from the asynchronous oscillator domain.
  input  wire logic [OSC_WIDTH-1:0] osc_raw [3],
  // Oscillator enables and current register selects.
  output logic                  core_osc_enable_q,
  output logic                  periph_osc_enable_q,
  output logic [7:0]            thread_sel_field_q,
  output logic [4:0]            reg_sel_field_q
);

  logic [OSC_WIDTH-1:0] osc_s1_q [3];
  logic [OSC_WIDTH-1:0] osc_s2_q [3];
  logic [31:0]          status_q;
  logic [31:0]          pc_q;
  logic [31:0]          sp_q;
  logic [2:0]           cause_q;
  logic [1:0]           trig_q;
  logic [7:0]           thread_q;
  logic [31:0]          data_q;
  logic [1:0]           lowest_hit;
  logic                 ext_cause;
  logic [31:0]          rd_d;

  // Two-flop samplers for each oscillator count, with no reset so a system
  // reset leaves the readable counts intact.
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_osc
      always_ff @(posedge clk) begin
        osc_s1_q[g] <= osc_raw[g];
        osc_s2_q[g] <= osc_s1_q[g];
      end
    end
  endgenerate

  // Lowest-numbered hit wins when several fire at once.
  always_comb begin
    lowest_hit = 2'h0;
    if (entry.hits[0]) begin
      lowest_hit = 2'h0;
    end else if (entry.hits[1]) begin
      lowest_hit = 2'h1;
    end else if (entry.hits[2]) begin
      lowest_hit = 2'h2;
    end else if (entry.hits[3]) begin
      lowest_hit = 2'h3;
    end
  end

  // Host and call entries carry no trigger number.
  assign ext_cause = (entry.cause == CAUSE_HOST) || (entry.cause == CAUSE_CALL);

  // Oscillator enables, cleared at reset.
  always_ff @(posedge clk) begin
    if (rst) begin
      core_osc_enable_q   <= 1'b0;
      periph_osc_enable_q <= 1'b0;
    end else if (req.wr && req.idx == IDX_OSC_ENABLE) begin
      core_osc_enable_q   <= req.wdata[CORE_EN_BIT];
      periph_osc_enable_q <= req.wdata[PERIPH_EN_BIT];
    end
  end

  // Remote read operands; only the field bits are stored.
  always_ff @(posedge clk) begin
    if (rst) begin
      thread_sel_field_q <= 8'h00;
      reg_sel_field_q    <= 5'h00;
    end else if (req.wr) begin
      if (req.idx == IDX_THREAD_SEL) begin
        thread_sel_field_q <= req.wdata[7:0];
      end
      if (req.idx == IDX_REG_SEL) begin
        reg_sel_field_q <= req.wdata[4:0];
      end
    end
  end

  // Saved status, program counter and stack pointer: captured on entry,
  // otherwise writable by the debugger. Entry wins over a same-cycle write.
  always_ff @(posedge clk) begin
    if (rst) begin
      status_q <= 32'h0000_0000;
      pc_q     <= 32'h0000_0000;
      sp_q     <= 32'h0000_0000;
    end else if (entry.valid) begin
      status_q <= entry.status & STATUS_CAP_MASK;
      pc_q     <= entry.pc;
      sp_q     <= entry.sp;
    end else if (req.wr) begin
      if (req.idx == IDX_SAVED_STATUS) begin
        status_q <= (status_q & ~STATUS_WR_MASK) | (req.wdata & STATUS_WR_MASK);
      end
      if (req.idx == IDX_SAVED_PC) begin
        pc_q <= req.wdata;
      end
      if (req.idx == IDX_SAVED_SP) begin
        sp_q <= req.wdata;
      end
    end
  end

  // Entry cause, trigger number and thread; entry wins over a write.
  always_ff @(posedge clk) begin
    if (rst) begin
      cause_q  <= CAUSE_NONE;
      trig_q   <= 2'h0;
      thread_q <= 8'h00;
    end else if (entry.valid) begin
      cause_q  <= entry.cause;
      trig_q   <= ext_cause ? 2'h0 : lowest_hit;
      thread_q <= (entry.cause == CAUSE_HOST) ? 8'h00 : entry.thread;
    end else if (req.wr && req.idx == IDX_ENTRY_CAUSE) begin
      cause_q  <= req.wdata[2:0];
      trig_q   <= req.wdata[17:16];
      thread_q <= req.wdata[15:8];
    end
  end

  // Entry data: address on data watchpoint, resource id on resource watchpoint.
  always_ff @(posedge clk) begin
    if (rst) begin
      data_q <= 32'h0000_0000;
    end else if (entry.valid &&
                 (entry.cause == CAUSE_DWATCH || entry.cause == CAUSE_RWATCH)) begin
      data_q <= entry.data;
    end else if (req.wr && req.idx == IDX_ENTRY_DATA) begin
      data_q <= req.wdata;
    end
  end

  // Read multiplexer; reserved bits and unmapped indices read zero.
  always_comb begin
    rd_d = 32'h0000_0000;
    case (req.idx)
      IDX_TILE_WIRE_OSC:   rd_d = {16'h0000, osc_s2_q[0]};
      IDX_PERIPH_CELL_OSC: rd_d = {16'h0000, osc_s2_q[1]};
      IDX_PERIPH_WIRE_OSC: rd_d = {16'h0000, osc_s2_q[2]};
      IDX_MEM_CAPACITY:    rd_d = {MEM_BYTES[31:2], 2'b00};
      IDX_SAVED_STATUS:    rd_d = status_q;
      IDX_SAVED_PC:        rd_d = pc_q;
      IDX_SAVED_SP:        rd_d = sp_q;
      IDX_THREAD_SEL:      rd_d = {24'h000000, thread_sel_field_q};
      IDX_REG_SEL:         rd_d = {27'h0, reg_sel_field_q};
      IDX_ENTRY_CAUSE:     rd_d = {14'h0, trig_q, thread_q, 5'h00, cause_q};
      IDX_ENTRY_DATA:      rd_d = data_q;
      IDX_OSC_ENABLE:      rd_d = {30'h0, core_osc_enable_q, periph_osc_enable_q};
      default:             rd_d = 32'h0000_0000;
    endcase
  end

  // Read data stands the cycle after the read strobe only.
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (req.rd) begin
      rdata_q <= rd_d;
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

endmodule

// ==== src/dcs_pkg.sv ====
/*
  Constants, register offsets, field layouts and carrier types for the debug
  capture and status register bank.
  Assumes a single core clock domain and a plain strobe register port.
*/
// Behaviour
// - Oscillator count in low 16 bits only
// - Oscillator counts survive system reset
// - Three count registers, three oscillators
// - Memory capacity read-only, bytes in 31:2
// - Debug entry copies saved status word
// - Status bits 0..4 event/irq/enable/handler/kernel
// - Status bits 6..10 wait/fast/issue/kedi/asid
// - Debug entry captures full program counter
// - Debug entry captures full stack pointer
// - Debugger writes 8-bit thread select
// - Debugger writes 5-bit register select
// - Three-bit cause code, values one to five
// - Trigger number, zero for host/call entries
// - Lowest simultaneous trigger number reported
// - Thread number, zero for host entry
// - Data watchpoint loads effective address
// - Resource watchpoint loads resource identifier
// - Separate oscillator enables, cleared at reset
package dcs_pkg;

  // Register indices; byte address is four times the index.
  localparam logic [7:0] IDX_TILE_WIRE_OSC   = 8'h08;
  localparam logic [7:0] IDX_PERIPH_CELL_OSC = 8'h09;
  localparam logic [7:0] IDX_PERIPH_WIRE_OSC = 8'h0a;
  localparam logic [7:0] IDX_MEM_CAPACITY    = 8'h0c;
  localparam logic [7:0] IDX_SAVED_STATUS    = 8'h10;
  localparam logic [7:0] IDX_SAVED_PC        = 8'h11;
  localparam logic [7:0] IDX_SAVED_SP        = 8'h12;
  localparam logic [7:0] IDX_THREAD_SEL      = 8'h13;
  localparam logic [7:0] IDX_REG_SEL         = 8'h14;
  localparam logic [7:0] IDX_ENTRY_CAUSE     = 8'h15;
  localparam logic [7:0] IDX_ENTRY_DATA      = 8'h16;
  localparam logic [7:0] IDX_OSC_ENABLE      = 8'h3c;

  // Writable status bits: 10,9,7,6,4..0; bit 8 read-only, 5 and 31:11 reserved.
  localparam logic [31:0] STATUS_WR_MASK  = 32'h0000_06df;
  localparam logic [31:0] STATUS_CAP_MASK = 32'h0000_07df;
  localparam int          OSC_WIDTH       = 16;
  localparam int          CORE_EN_BIT     = 1;
  localparam int          PERIPH_EN_BIT   = 0;

  // Cause codes.
  localparam logic [2:0] CAUSE_NONE     = 3'h0;
  localparam logic [2:0] CAUSE_HOST     = 3'h1;
  localparam logic [2:0] CAUSE_CALL     = 3'h2;
  localparam logic [2:0] CAUSE_IBREAK   = 3'h3;
  localparam logic [2:0] CAUSE_DWATCH   = 3'h4;
  localparam logic [2:0] CAUSE_RWATCH   = 3'h5;

  // Debug entry event from the core.
  typedef struct packed {
    logic        valid;
    logic [2:0]  cause;
    logic [3:0]  hits;
    logic [7:0]  thread;
    logic [31:0] status;
    logic [31:0] pc;
    logic [31:0] sp;
    logic [31:0] data;
  } dcs_entry_t;

  // Register port request.
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  idx;
    logic [31:0] wdata;
  } dcs_req_t;

endpackage

// ==== sim/dcs_regs_properties.sv ====
/* Checker for the debug capture and status register bank.
   Bound to dcs_regs; sees only its ports, one clock domain. */
`timescale 1ns/1ps
module dcs_regs_properties
  import dcs_pkg::*;
#(
  parameter logic [31:0] MEM_BYTES = 32'h0008_0000
) (
  // Watched ports.
  input wire logic        clk,
  input wire logic        rst,
  input wire dcs_req_t    req,
  input wire logic [31:0] rdata_q,
  input wire dcs_entry_t  entry,
  input wire logic [7:0]  thread_sel_field_q,
  input wire logic [4:0]  reg_sel_field_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Strobes at one register index.
  sequence rd_at(logic [7:0] i); req.rd && req.idx == i; endsequence
  sequence wr_at(logic [7:0] i); req.wr && req.idx == i; endsequence
  // Entry followed at once by a read of a captured register.
  sequence ent_rd(logic [7:0] i); entry.valid ##1 rd_at(i); endsequence
  cause_code_a: assert property (ent_rd(IDX_ENTRY_CAUSE) |=>
    rdata_q[2:0] == $past(entry.cause, 2)) else $error("cause code lost");
  host_zero_a: assert property (entry.valid && entry.cause == CAUSE_HOST ##1 rd_at(IDX_ENTRY_CAUSE) |=>
    rdata_q[17:8] == 10'h0) else $error("host entry fields not zero");
  thread_num_a: assert property (entry.valid && entry.cause != CAUSE_HOST ##1 rd_at(IDX_ENTRY_CAUSE) |=>
    rdata_q[15:8] == $past(entry.thread, 2)) else $error("thread number lost");
  pc_capture_a: assert property (ent_rd(IDX_SAVED_PC) |=>
    rdata_q == $past(entry.pc, 2)) else $error("program counter lost");
  status_mask_a: assert property (rd_at(IDX_SAVED_STATUS) |=>
    (rdata_q & ~STATUS_CAP_MASK) == 32'h0) else $error("status reserved bits set");
  osc_upper_a: assert property (req.rd && req.idx inside {[8'h08:8'h0a]} |=>
    rdata_q[31:16] == 16'h0) else $error("count upper half set");
  mem_size_a: assert property (rd_at(IDX_MEM_CAPACITY) |=>
    rdata_q == {MEM_BYTES[31:2], 2'b00}) else $error("capacity wrong");
  thread_sel_a: assert property (wr_at(IDX_THREAD_SEL) |=>
    thread_sel_field_q == $past(req.wdata[7:0])) else $error("thread select lost");
  reg_sel_a: assert property (wr_at(IDX_REG_SEL) |=>
    reg_sel_field_q == $past(req.wdata[4:0])) else $error("register select lost");
endmodule
bind dcs_regs dcs_regs_properties #(.MEM_BYTES(MEM_BYTES)) chk_u (.clk(clk), .rst(rst), .req(req),
  .rdata_q(rdata_q), .entry(entry), .thread_sel_field_q(thread_sel_field_q), .reg_sel_field_q(reg_sel_field_q));

// ==== sim/dcs_host_model.sv ====
/* Debugger-side model driving the register port with one-cycle strobes.
   Assumes read data stands only in the cycle after the read strobe. */
`timescale 1ns/1ps
module dcs_host_model
  import dcs_pkg::*;
(
  // Clock and register port.
  input  wire logic        clk,
  output dcs_req_t         req,
  input  wire logic [31:0] rdata_q
);
  // The port idles until a task runs.
  initial req = '0;
  // One write; operand selects reach the bank this way.
  task automatic wr_reg(input logic [7:0] i, input logic [31:0] w);
    req <= '{1'b1, 1'b0, i, w};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
  endtask
  // One read; data is taken once the strobe edge has landed.
  task automatic rd_reg(input logic [7:0] i, output logic [31:0] r);
    req <= '{1'b0, 1'b1, i, 32'h0};
    @(posedge clk);
    req <= '0;
    #1;
    r = rdata_q;
    @(posedge clk);
  endtask
endmodule

// ==== sim/tb_debug_capture_status_regs.sv ====
/* Self-checking bench for the debug capture and status register bank.
   Assumes the package indices and masks and a 250 MHz core clock. */
`timescale 1ns/1ps
module tb_debug_capture_status_regs
  import dcs_pkg::*;
;
  localparam logic [31:0] MEM = 32'h0001_0004;
  logic        clk, rst, core_en, periph_en;
  dcs_req_t    req;
  dcs_entry_t  entry, e;
  logic [31:0] d, w, exp_v [5];
  logic [15:0] osc_raw [3];
  logic [7:0]  tsel;
  logic [4:0]  rsel;
  int          mismatches, n_compared, m;
  logic [7:0]  ids [5] = '{IDX_ENTRY_CAUSE, IDX_SAVED_PC, IDX_SAVED_SP, IDX_SAVED_STATUS, IDX_ENTRY_DATA};
  // Bits that a debugger write may change, in the order of ids.
  logic [31:0] wmask [5] = '{32'h0003_ff07, 32'hffff_ffff, 32'hffff_ffff, STATUS_WR_MASK, 32'hffff_ffff};
  logic [31:0] rdata_q_w;
  dcs_regs #(.MEM_BYTES(MEM)) dut_u (.clk(clk), .rst(rst), .req(req), .rdata_q(rdata_q_w), .entry(entry),
    .osc_raw(osc_raw), .core_osc_enable_q(core_en), .periph_osc_enable_q(periph_en),
    .thread_sel_field_q(tsel), .reg_sel_field_q(rsel));
  dcs_host_model host_u (.clk(clk), .req(req), .rdata_q(rdata_q_w));
  // Expected cause word: lowest hit, trigger zero for host and call entries, thread zero for host.
  function automatic logic [31:0] cause_word(dcs_entry_t x);
    logic [1:0] t;
    t = 2'h0;
    for (int b = 3; b >= 0; b--) if (x.hits[b]) t = b[1:0];
    if (x.cause == CAUSE_HOST || x.cause == CAUSE_CALL) t = 2'h0;
    return {14'h0, t, (x.cause == CAUSE_HOST) ? 8'h0 : x.thread, 5'h0, x.cause};
  endfunction
  // Compare and count.
  task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
    n_compared++;
    if (seen !== expv) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, expv);
    end
  endtask
  // Verdict and end of run.
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Clock of 4 ns.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Watchdog against a hang.
  initial begin
    repeat (4000) @(posedge clk);
    mismatches++;
    print_verdict();
  end
  // Main sequence.
  initial begin
    rst = 1'b1;
    entry = '0;
    mismatches = 0;
    n_compared = 0;
    exp_v = '{default: 32'h0};
    foreach (osc_raw[i]) osc_raw[i] = 16'h0;
    void'($urandom(32'h6880c445));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // Read-only capacity and an unmapped place.
    host_u.wr_reg(IDX_MEM_CAPACITY, 32'hffff_ffff);
    host_u.rd_reg(IDX_MEM_CAPACITY, d);
    chk(d, {MEM[31:2], 2'b00});
    host_u.rd_reg(8'h3f, d);
    chk(d, 32'h0);
    // Random operands and status words through their masks.
    repeat (12) begin
      w = $urandom();
      host_u.wr_reg(IDX_THREAD_SEL, w);
      host_u.wr_reg(IDX_REG_SEL, w);
      chk({19'h0, tsel, rsel}, {19'h0, w[7:0], w[4:0]});
      // Every debugger-writable capture register, through its write mask.
      foreach (ids[n]) begin
        host_u.wr_reg(ids[n], w);
        host_u.rd_reg(ids[n], d);
        chk(d, w & wmask[n]);
      end
    end
    // Run, load counts, stop, wait, read; again after a reset.
    host_u.wr_reg(IDX_OSC_ENABLE, 32'h2);
    chk({30'h0, core_en, periph_en}, 32'h2);
    foreach (osc_raw[i]) osc_raw[i] <= 16'($urandom());
    host_u.wr_reg(IDX_OSC_ENABLE, 32'h0);
    repeat (10) @(posedge clk);
    for (int k = 0; k < 2; k++) begin
      foreach (osc_raw[i]) begin
        host_u.rd_reg(IDX_TILE_WIRE_OSC + 8'(i), d);
        chk(d, {16'h0, osc_raw[i]});
      end
      host_u.wr_reg(IDX_OSC_ENABLE, 32'(3 - 2 * k));
      chk({30'h0, core_en, periph_en}, 32'(3 - 2 * k));
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk({30'h0, core_en, periph_en}, 32'h0);
    end
    // Every cause twice, captured registers read in rotating order.
    for (int k = 0; k < 10; k++) begin
      e = '{1'b1, 3'(k % 5 + 1), 4'($urandom_range(1, 15)), 8'($urandom()), $urandom(), $urandom(),
            $urandom(), $urandom()};
      exp_v = '{cause_word(e), e.pc, e.sp, e.status & STATUS_CAP_MASK, (e.cause > CAUSE_IBREAK) ? e.data : exp_v[4]};
      entry <= e;
      @(posedge clk);
      entry.valid <= 1'b0;
      for (int j = 0; j < 5; j++) begin
        m = (k + j + k / 5) % 5;
        host_u.rd_reg(ids[m], d);
        chk(d, exp_v[m]);
      end
    end
    print_verdict();
  end
endmodule
